// ==== core/dsl_top.sv ====
// serial programming latches, phase detector, lock detect and status mux
// Behaviour
// (R1) shift one data bit per serial clock rise
// (R2) host sends bit 23 first, bit 0 last
// (R3) strobe rise copies word into one latch
// (R4) word bits 1 and 0 pick the latch
// (R5) 00 IF ref, 01 IF fb, 10 RF ref, 11 RF fb
// (R6) ref latch: ratio 16:2, current, control bits
// (R7) fb latch: swallow, main, prescale, power, gain
// (R8) feedback divider: 6-bit swallow, 12-bit main
// (R9) detector compares reference and feedback edges
// (R10) fixed anti-backlash pulse on both pumps
// (R11) four latch bits choose the status output
// (R12) status shows digital or analog lock
// (R13) lock sets after three errors below 15 ns
// (R14) lock clears on an error above 25 ns
// (R15) analog lock: open-drain, low per error pulse
// (R16) feedback ratio is P times main plus swallow
// (R17) prescaler select: 8, 16, 32 or 64
// (R18) reference ratio 1 to 32767, field equals ratio
`timescale 1ns/1ns
`default_nettype none
`include "dsl_params.svh"

module dsl_top (
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	input  wire logic       serial_clk_i,
	input  wire logic       serial_data_i,
	input  wire logic       load_strobe_i,
	input  wire logic       ref_in_i,
	input  wire logic       if_in_i,
	input  wire logic       rf_in_i,
	output logic            if_pump_up_o,
	output logic            if_pump_dn_o,
	output logic            if_pump_hiz_o,
	output logic            rf_pump_up_o,
	output logic            rf_pump_dn_o,
	output logic            rf_pump_hiz_o,
	output logic [2:0]      if_pump_current_o,
	output logic [2:0]      rf_pump_current_o,
	output logic            if_pump_gain_o,
	output logic            rf_pump_gain_o,
	output logic            if_power_down_o,
	output logic            rf_power_down_o,
	output logic            status_mux_output_o,
	output logic            status_mux_output_oe_n_o
);

	dsl_pkg::dsl_top_s  q;
	dsl_pkg::dsl_top_s  n;
	dsl_pkg::dsl_word_t word;
	dsl_pkg::dsl_mux_e  mux_sel;
	logic               load;
	logic [1:0]         ref_ev;
	logic [1:0]         fb_ev;
	logic [1:0]         vco_pins;
	logic [1:0]         clr_w;
	logic [1:0]         bad_w;

	// two status select bits of a reference latch, high bit first
	function automatic logic [1:0] stat_bits(input dsl_pkg::dsl_word_t w);
		stat_bits = {w[`DSL_STAT_HI_BIT], w[`DSL_STAT_LO_BIT]};
	endfunction

	dsl_shift_in u_shift (
		.clk_i         (clk_i),
		.rstn_i        (rstn_i),
		.serial_clk_i  (serial_clk_i),
		.serial_data_i (serial_data_i),
		.load_strobe_i (load_strobe_i),
		.word_o        (word),
		.load_o        (load)
	);

	assign vco_pins = {rf_in_i, if_in_i};

	// channel 0 is IF, channel 1 is RF; latch 2g is reference, 2g+1 feedback
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_chan
			dsl_div_chan u_div (
				.clk_i     (clk_i),
				.rstn_i    (rstn_i),
				.ref_pin_i (ref_in_i),
				.vco_pin_i (vco_pins[g]),
				.ratio_i   (q.lat[2*g][`DSL_RATIO_HI:`DSL_RATIO_LO]),  // R6
				.swallow_i (q.lat[2*g+1][`DSL_SWAL_HI:`DSL_SWAL_LO]),  // R7
				.main_i    (q.lat[2*g+1][`DSL_MAIN_HI:`DSL_MAIN_LO]),  // R7
				.psel_i    (q.lat[2*g+1][`DSL_PSEL_HI:`DSL_PSEL_LO]),  // R7
				.pdown_i   (q.lat[2*g+1][`DSL_PDOWN_BIT]),             // R7
				.ref_ev_o  (ref_ev[g]),
				.fb_ev_o   (fb_ev[g])
			);
		end
	endgenerate

	assign mux_sel = dsl_pkg::dsl_mux_e'({stat_bits(q.lat[`DSL_SEL_RF_REF]),
		stat_bits(q.lat[`DSL_SEL_IF_REF])});  // R11

	always_comb begin
		logic a_ev;
		logic b_ev;
		logic clr;
		logic good;
		logic bad;
		logic both;
		logic tri_st;
		logic pdown;
		a_ev = 1'b0;
		b_ev = 1'b0;
		clr = 1'b0;
		good = 1'b0;
		bad = 1'b0;
		both = 1'b0;
		tri_st = 1'b0;
		pdown = 1'b0;
		clr_w = 2'b00;
		bad_w = 2'b00;
		n = q;
		if (load) begin
			n.lat[word[1:0]] = word;  // R3 R4 R5
		end
		for (int c = 0; c < 2; c++) begin
			tri_st = q.lat[2*c][`DSL_TRI_BIT];  // R6
			pdown = q.lat[2*c+1][`DSL_PDOWN_BIT];
			// positive polarity pumps up when the reference leads
			a_ev = q.lat[2*c][`DSL_POL_BIT] ? ref_ev[c] : fb_ev[c];  // R9
			b_ev = q.lat[2*c][`DSL_POL_BIT] ? fb_ev[c] : ref_ev[c];
			both = q.up[c] & q.dn[c];
			clr = both & (q.abl[c] == 4'(`DSL_ABL_CYC - 1));  // R10
			n.abl[c] = (both & ~clr) ? q.abl[c] + 4'h1 : 4'h0;
			// a new edge in the clearing cycle is kept, not lost
			n.up[c] = (q.up[c] & ~clr) | a_ev;  // R9
			n.dn[c] = (q.dn[c] & ~clr) | b_ev;
			if ((q.up[c] ^ q.dn[c]) && q.err[c] != `DSL_ERR_MAX) begin
				n.err[c] = q.err[c] + 8'h01;
			end
			good = clr & (q.err[c] <= 8'(`DSL_LOCK_CYC));  // R13
			// a saturated error means the other edge stopped coming
			bad = (clr & (q.err[c] > 8'(`DSL_UNLOCK_CYC))) |
				(q.err[c] == `DSL_ERR_MAX);  // R14
			if (clr) begin
				n.err[c] = 8'h00;
				if (!good) begin
					n.good[c] = 2'h0;
				end else if (q.good[c] != 2'(`DSL_LOCK_RUN)) begin
					n.good[c] = q.good[c] + 2'h1;
				end
			end
			if (bad) begin
				n.lock[c] = 1'b0;  // R14
			end else if (good && q.good[c] >= 2'(`DSL_LOCK_RUN - 1)) begin
				n.lock[c] = 1'b1;  // R13
			end
			if (pdown) begin
				n.up[c] = 1'b0;
				n.dn[c] = 1'b0;
				n.abl[c] = 4'h0;
				n.err[c] = 8'h00;
				n.good[c] = 2'h0;
				n.lock[c] = 1'b0;
			end
			n.pup[c] = n.up[c] & ~tri_st & ~pdown;
			n.pdn[c] = n.dn[c] & ~tri_st & ~pdown;
			n.hiz[c] = tri_st | pdown;
			n.al[c] = n.up[c] ^ n.dn[c];  // R15
			clr_w[c] = clr;
			bad_w[c] = bad;
		end
		n.smo = 1'b0;
		n.smo_oe_n = 1'b0;
		case (mux_sel)  // R11 R12
			dsl_pkg::DSL_MUX_IF_DLOCK: begin
				n.smo = q.lock[0];
			end
			dsl_pkg::DSL_MUX_IF_ALOCK: begin
				n.smo_oe_n = ~q.al[0];  // R15
			end
			dsl_pkg::DSL_MUX_IF_REF: begin
				n.smo = ref_ev[0];
			end
			dsl_pkg::DSL_MUX_IF_FB: begin
				n.smo = fb_ev[0];
			end
			dsl_pkg::DSL_MUX_RF_DLOCK: begin
				n.smo = q.lock[1];
			end
			dsl_pkg::DSL_MUX_RF_ALOCK: begin
				n.smo_oe_n = ~q.al[1];  // R15
			end
			dsl_pkg::DSL_MUX_RF_REF: begin
				n.smo = ref_ev[1];
			end
			dsl_pkg::DSL_MUX_RF_FB: begin
				n.smo = fb_ev[1];
			end
			dsl_pkg::DSL_MUX_BOTH_DLOCK: begin
				n.smo = q.lock[0] & q.lock[1];
			end
			dsl_pkg::DSL_MUX_BOTH_ALOCK: begin
				n.smo_oe_n = ~(q.al[0] | q.al[1]);
			end
			dsl_pkg::DSL_MUX_HIGH: begin
				n.smo = 1'b1;
			end
			default: begin
				n.smo = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign if_pump_up_o = q.pup[0];
	assign if_pump_dn_o = q.pdn[0];
	assign if_pump_hiz_o = q.hiz[0];
	assign rf_pump_up_o = q.pup[1];
	assign rf_pump_dn_o = q.pdn[1];
	assign rf_pump_hiz_o = q.hiz[1];
	assign if_pump_current_o = q.lat[`DSL_SEL_IF_REF][`DSL_CUR_HI:`DSL_CUR_LO];
	assign rf_pump_current_o = q.lat[`DSL_SEL_RF_REF][`DSL_CUR_HI:`DSL_CUR_LO];
	assign if_pump_gain_o = q.lat[`DSL_SEL_IF_FB][`DSL_GAIN_BIT];
	assign rf_pump_gain_o = q.lat[`DSL_SEL_RF_FB][`DSL_GAIN_BIT];
	assign if_power_down_o = q.lat[`DSL_SEL_IF_FB][`DSL_PDOWN_BIT];
	assign rf_power_down_o = q.lat[`DSL_SEL_RF_FB][`DSL_PDOWN_BIT];
	assign status_mux_output_o = q.smo;
	assign status_mux_output_oe_n_o = q.smo_oe_n;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	AST_LATCH_ONLY_ON_LOAD: assert property (!load |=> $stable(q.lat))  // R3
		else $error("a latch changed without a load");
	AST_LATCH_TARGET: assert property (load |=>  // R4
		q.lat[$past(word[1:0])] == $past(word))
		else $error("loaded word missing from its latch");
	AST_SEL_IF_FB: assert property ((load && word[1:0] == 2'b01) |=>  // R5
		q.lat[1] == $past(word) && $stable(q.lat[0]) && $stable(q.lat[3]))
		else $error("select 01 did not load the IF feedback latch");
	AST_SEL_RF_REF: assert property ((load && word[1:0] == 2'b10) |=>  // R5
		q.lat[2] == $past(word) && $stable(q.lat[1]))
		else $error("select 10 did not load the RF reference latch");
	AST_PUMP_CURRENT: assert property ((load && word[1:0] == 2'b00) |=>  // R6
		if_pump_current_o == $past(word[`DSL_CUR_HI:`DSL_CUR_LO]))
		else $error("IF pump current not taken from bits 23 to 21");
	AST_POWER_DOWN: assert property ((load && word[1:0] == 2'b11) |=>  // R7
		rf_power_down_o == $past(word[`DSL_PDOWN_BIT]))
		else $error("RF power down not taken from bit 22");
	AST_UP_ON_REF: assert property ((ref_ev[0] && !fb_ev[0] && !q.up[0] &&
		!q.dn[0] && q.lat[0][`DSL_POL_BIT] && !q.lat[1][`DSL_PDOWN_BIT])  // R9
		|=> q.up[0] && !q.dn[0]) else $error("reference edge did not pump up");
	AST_ANTI_BACKLASH: assert property ((q.up[0] && q.dn[0]) |=>  // R10
		!(q.up[0] && q.dn[0])) else $error("anti-backlash pulse too long");
	AST_STATUS_DLOCK: assert property ((mux_sel == dsl_pkg::DSL_MUX_IF_DLOCK)
		|=> status_mux_output_o == $past(q.lock[0]))  // R12
		else $error("status output does not show IF lock");
	AST_STATUS_LOW: assert property ((mux_sel == dsl_pkg::DSL_MUX_LOW)  // R11
		|=> !status_mux_output_o && !status_mux_output_oe_n_o)
		else $error("status select 0 does not drive low");
	AST_LOCK_SET: assert property ($rose(q.lock[0]) |->  // R13
		q.good[0] == 2'h3 && $past(clr_w[0]))
		else $error("lock set without three good comparisons");
	AST_LOCK_CLEAR: assert property (bad_w[0] |=> !q.lock[0])  // R14
		else $error("lock kept after a large phase error");
	AST_LOCK_HOLD: assert property ((q.lock[0] && !bad_w[0] &&
		!q.lat[1][`DSL_PDOWN_BIT]) |=> q.lock[0])  // R14
		else $error("lock dropped without a large phase error");
	AST_ANALOG_OPEN_DRAIN: assert property ((mux_sel ==
		dsl_pkg::DSL_MUX_IF_ALOCK) |=> !status_mux_output_o &&
		status_mux_output_oe_n_o == !$past(q.al[0]))  // R15
		else $error("analog lock not an open-drain pull-down");
	AST_TRISTATE: assert property (q.lat[0][`DSL_TRI_BIT] |=>  // R6
		!if_pump_up_o && !if_pump_dn_o)
		else $error("IF pump driven while in three-state");

	COV_LOAD_RF_FB: cover property (load && word[1:0] == 2'b11);
	COV_IF_LOCK: cover property ($rose(q.lock[0]));
	COV_IF_UNLOCK: cover property ($fell(q.lock[0]));
	COV_ANALOG_PULSE: cover property ((mux_sel == dsl_pkg::DSL_MUX_IF_ALOCK)
		##1 !status_mux_output_oe_n_o);

endmodule
`default_nettype wire

// ==== core/dsl_params.svh ====
// constants for the dual synthesizer serial program and lock block
`ifndef DSL_PARAMS_SVH
`define DSL_PARAMS_SVH

`define DSL_WORD_W      24
`define DSL_SEL_IF_REF  2'h0
`define DSL_SEL_IF_FB   2'h1
`define DSL_SEL_RF_REF  2'h2
`define DSL_SEL_RF_FB   2'h3
`define DSL_LATCH_RST   24'h000000

`define DSL_RATIO_HI    16
`define DSL_RATIO_LO    2
`define DSL_CUR_HI      23
`define DSL_CUR_LO      21
`define DSL_STAT_HI_BIT 20
`define DSL_STAT_LO_BIT 19
`define DSL_TRI_BIT     18
`define DSL_POL_BIT     17

`define DSL_SWAL_HI     7
`define DSL_SWAL_LO     2
`define DSL_MAIN_HI     19
`define DSL_MAIN_LO     8
`define DSL_PSEL_HI     21
`define DSL_PSEL_LO     20
`define DSL_PDOWN_BIT   22
`define DSL_GAIN_BIT    23
`define DSL_PRESC_BASE  7'h08

`define DSL_CLK_NS      8
`define DSL_ABL_NS      3
`define DSL_ABL_CYC     (((`DSL_ABL_NS) + (`DSL_CLK_NS) - 1) / (`DSL_CLK_NS))
`define DSL_LOCK_NS     15
`define DSL_LOCK_CYC    (((`DSL_LOCK_NS) / (`DSL_CLK_NS)) < 1 ? 1 : \
	((`DSL_LOCK_NS) / (`DSL_CLK_NS)))
`define DSL_UNLOCK_NS   25
`define DSL_UNLOCK_CYC  (((`DSL_UNLOCK_NS) / (`DSL_CLK_NS)) < 1 ? 1 : \
	((`DSL_UNLOCK_NS) / (`DSL_CLK_NS)))
`define DSL_LOCK_RUN    3
`define DSL_ERR_MAX     8'hff

`endif

// ==== core/dsl_pkg.sv ====
// types shared by the serial program and lock block
`include "dsl_params.svh"

package dsl_pkg;

	typedef logic [`DSL_WORD_W-1:0] dsl_word_t;

	typedef enum logic [3:0] {
		DSL_MUX_LOW,
		DSL_MUX_IF_DLOCK,
		DSL_MUX_IF_ALOCK,
		DSL_MUX_IF_REF,
		DSL_MUX_IF_FB,
		DSL_MUX_RF_DLOCK,
		DSL_MUX_RF_ALOCK,
		DSL_MUX_RF_REF,
		DSL_MUX_RF_FB,
		DSL_MUX_BOTH_DLOCK,
		DSL_MUX_BOTH_ALOCK,
		DSL_MUX_HIGH
	} dsl_mux_e;

	typedef struct packed {
		logic [2:0] ck;
		logic [1:0] dt;
		logic [2:0] le;
		dsl_word_t  sreg;
		logic       load;
	} dsl_shift_s;

	typedef struct packed {
		logic [2:0]  ref_sy;
		logic [2:0]  vco_sy;
		logic [14:0] rcnt;
		logic [6:0]  pcnt;
		logic [5:0]  scnt;
		logic [11:0] bcnt;
		logic        ref_ev;
		logic        fb_ev;
		logic [14:0] hr;
		logic [17:0] hf;
		logic        okr;
		logic        okf;
		logic [34:0] cfg;
	} dsl_div_s;

	typedef struct packed {
		logic [3:0][`DSL_WORD_W-1:0] lat;
		logic [1:0]                  up;
		logic [1:0]                  dn;
		logic [1:0][3:0]             abl;
		logic [1:0][7:0]             err;
		logic [1:0][1:0]             good;
		logic [1:0]                  lock;
		logic [1:0]                  al;
		logic [1:0]                  pup;
		logic [1:0]                  pdn;
		logic [1:0]                  hiz;
		logic                        smo;
		logic                        smo_oe_n;
	} dsl_top_s;

endpackage

// ==== core/dsl_shift_in.sv ====
// serial word shifter and load strobe edge finder
`timescale 1ns/1ns
`default_nettype none
`include "dsl_params.svh"

module dsl_shift_in (
	input  wire logic              clk_i,
	input  wire logic              rstn_i,
	input  wire logic              serial_clk_i,
	input  wire logic              serial_data_i,
	input  wire logic              load_strobe_i,
	output var dsl_pkg::dsl_word_t word_o,
	output logic                   load_o
);

	dsl_pkg::dsl_shift_s q;
	dsl_pkg::dsl_shift_s n;

	always_comb begin
		n = q;
		n.ck = {q.ck[1:0], serial_clk_i};
		n.dt = {q.dt[0], serial_data_i};
		n.le = {q.le[1:0], load_strobe_i};
		// data sits two stages deep, the same age as the clock edge
		if (q.ck[1] & ~q.ck[2]) begin
			n.sreg = {q.sreg[`DSL_WORD_W-2:0], q.dt[1]};  // R1 R2
		end
		n.load = q.le[1] & ~q.le[2];  // R3
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign word_o = q.sreg;
	assign load_o = q.load;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	AST_SHIFT_HOLD: assert property (!(q.ck[1] && !q.ck[2]) |=>  // R1
		$stable(q.sreg)) else $error("shift register moved without clock");
	AST_SHIFT_BIT: assert property ((q.ck[1] && !q.ck[2]) |=>  // R1
		q.sreg[0] == $past(q.dt[1])) else $error("shifted bit wrong");
	AST_LOAD_PULSE: assert property (load_o |=> !load_o)  // R3
		else $error("load pulse longer than one cycle");

endmodule
`default_nettype wire

// ==== core/dsl_div_chan.sv ====
// reference and dual-modulus feedback dividers of one synthesizer
`timescale 1ns/1ns
`default_nettype none
`include "dsl_params.svh"

module dsl_div_chan (
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        ref_pin_i,
	input  wire logic        vco_pin_i,
	input  wire logic [14:0] ratio_i,
	input  wire logic [5:0]  swallow_i,
	input  wire logic [11:0] main_i,
	input  wire logic [1:0]  psel_i,
	input  wire logic        pdown_i,
	output logic             ref_ev_o,
	output logic             fb_ev_o
);

	dsl_pkg::dsl_div_s q;
	dsl_pkg::dsl_div_s n;
	logic [14:0] ratio;
	logic [11:0] bmax;
	logic [6:0]  pmod;
	logic [6:0]  mod;
	logic        ref_edge;
	logic        vco_edge;
	logic        rwrap;
	logic        pwrap;
	logic        fwrap;

	always_comb begin
		n = q;
		n.ref_sy = {q.ref_sy[1:0], ref_pin_i};
		n.vco_sy = {q.vco_sy[1:0], vco_pin_i};
		ref_edge = q.ref_sy[1] & ~q.ref_sy[2];
		vco_edge = q.vco_sy[1] & ~q.vco_sy[2];
		ratio = (ratio_i == 15'h0000) ? 15'h0001 : ratio_i;  // R18
		bmax = (main_i == 12'h000) ? 12'h001 : main_i;
		pmod = `DSL_PRESC_BASE << psel_i;  // R17
		// the swallow count runs the prescaler at P+1 first, then P
		mod = pmod + {6'h00, q.scnt != 6'h00};  // R8 R16
		rwrap = ref_edge & (q.rcnt >= ratio - 15'h0001);
		pwrap = vco_edge & (q.pcnt >= mod - 7'h01);
		fwrap = pwrap & (q.bcnt >= bmax - 12'h001);
		if (ref_edge) begin
			n.rcnt = rwrap ? 15'h0000 : q.rcnt + 15'h0001;
			n.hr = rwrap ? 15'h0000 : q.hr + 15'h0001;
		end
		if (vco_edge) begin
			n.pcnt = pwrap ? 7'h00 : q.pcnt + 7'h01;
			n.hf = fwrap ? 18'h00000 : q.hf + 18'h00001;
		end
		if (pwrap) begin
			n.bcnt = fwrap ? 12'h000 : q.bcnt + 12'h001;  // R8
			if (q.scnt != 6'h00) begin
				n.scnt = q.scnt - 6'h01;
			end
			if (fwrap) begin
				n.scnt = swallow_i;  // R16
			end
		end
		n.ref_ev = rwrap;
		n.fb_ev = fwrap;
		n.cfg = {ratio_i, swallow_i, main_i, psel_i};
		if (rwrap) begin
			n.okr = 1'b1;
		end
		if (fwrap) begin
			n.okf = 1'b1;
		end
		if (n.cfg != q.cfg) begin
			n.okr = 1'b0;
			n.okf = 1'b0;
		end
		if (pdown_i) begin
			n.rcnt = 15'h0000;
			n.pcnt = 7'h00;
			n.bcnt = 12'h000;
			n.scnt = swallow_i;
			n.ref_ev = 1'b0;
			n.fb_ev = 1'b0;
			n.okr = 1'b0;
			n.okf = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign ref_ev_o = q.ref_ev;
	assign fb_ev_o = q.fb_ev;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	AST_FB_RATIO: assert property ((fwrap && q.okf && !pdown_i) |->  // R16
		q.hf + 18'h00001 == 18'(pmod) * 18'(bmax) + 18'(swallow_i))
		else $error("feedback period is not P*B+A edges");
	AST_REF_RATIO: assert property ((rwrap && q.okr && !pdown_i) |->  // R18
		q.hr + 15'h0001 == ratio) else $error("reference period wrong");
	AST_SWALLOW: assert property ((q.okf && !pdown_i) |->  // R8
		q.scnt <= swallow_i) else $error("swallow count out of range");

endmodule
`default_nettype wire

// ==== dv/dsl_host.sv ====
// host model driving the three-wire programming port
`timescale 1ns/1ns
`default_nettype none

module dsl_host (
	input  wire logic clk_i,
	output logic      serial_clk_o,
	output logic      serial_data_o,
	output logic      load_strobe_o
);

	// half of the 160 ns serial clock period, counted in 8 ns cycles
	localparam int HALF = 10;

	initial begin
		serial_clk_o = 1'b0;
		serial_data_o = 1'b0;
		load_strobe_o = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// call right after a clock edge; the serial clock rests low between words
	task automatic send_word(input logic [23:0] w, input bit load);
		for (int i = 23; i >= 0; i--) begin
			serial_data_o <= w[i];
			tick(HALF);
			serial_clk_o <= 1'b1;
			tick(HALF);
			serial_clk_o <= 1'b0;
		end
		// data line has no pull, so show the inverse once the word is over
		serial_data_o <= ~w[0];
		tick(HALF);
		if (load) begin
			load_strobe_o <= 1'b1;
			tick(HALF);
			load_strobe_o <= 1'b0;
		end
		tick(HALF);
	endtask

endmodule

`default_nettype wire

// ==== dv/tb.sv ====
// self-checking bench for the serial program and lock block
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	n_mismatch++; $display("BAD %s exp %0h got %0h", nm, e, g); end end

module tb;

	logic        clk_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic        ref_in_i = 1'b0;
	logic        if_in_i = 1'b0;
	logic        sclk, sdata, lstrobe;
	logic        if_up, if_dn, if_hiz, rf_up, rf_dn, rf_hiz;
	logic [2:0]  if_cur, rf_cur;
	logic        if_gain, rf_gain, if_pd, rf_pd, smo, smo_oe_n;
	logic        run = 1'b0;
	int          p = 0;
	int          n_mismatch = 0;
	int          cmp_count = 0;
	logic [23:0] lat [4];
	logic [23:0] w;

	dsl_host host (
		.clk_i         (clk_i),
		.serial_clk_o  (sclk),
		.serial_data_o (sdata),
		.load_strobe_o (lstrobe)
	);

	dsl_top dut (
		.clk_i                    (clk_i),
		.rstn_i                   (rstn_i),
		.serial_clk_i             (sclk),
		.serial_data_i            (sdata),
		.load_strobe_i            (lstrobe),
		.ref_in_i                 (ref_in_i),
		.if_in_i                  (if_in_i),
		.rf_in_i                  (if_in_i),
		.if_pump_up_o             (if_up),
		.if_pump_dn_o             (if_dn),
		.if_pump_hiz_o            (if_hiz),
		.rf_pump_up_o             (rf_up),
		.rf_pump_dn_o             (rf_dn),
		.rf_pump_hiz_o            (rf_hiz),
		.if_pump_current_o        (if_cur),
		.rf_pump_current_o        (rf_cur),
		.if_pump_gain_o           (if_gain),
		.rf_pump_gain_o           (rf_gain),
		.if_power_down_o          (if_pd),
		.rf_power_down_o          (rf_pd),
		.status_mux_output_o      (smo),
		.status_mux_output_oe_n_o (smo_oe_n)
	);

	always #4 clk_i = ~clk_i;

	// vco at four cycles, reference at 32, eighth vco rise meets each ref rise
	always @(posedge clk_i) begin
		p <= run ? p + 1 : 0;
		// two missed vco pulses in mid-run shift the feedback by 8 cycles
		if_in_i <= run && !p[1] && !(p >= 260 && p < 268);
		ref_in_i <= run && p % 32 >= 28 && p % 32 < 30;
	end

	task automatic check();
		logic [23:0] ir, ifb, rr, rfb;
		logic [3:0]  sel;
		logic        alk;
		ir = lat[0];
		ifb = lat[1];
		rr = lat[2];
		rfb = lat[3];
		sel = {rr[20:19], ir[20:19]};
		alk = sel == 4'h2 || sel == 4'h6 || sel == 4'ha;
		@(negedge clk_i);
		`CHK("if_cur", ir[23:21], if_cur)
		`CHK("rf_cur", rr[23:21], rf_cur)
		`CHK("if_gain", ifb[23], if_gain)
		`CHK("rf_gain", rfb[23], rf_gain)
		`CHK("if_pd", ifb[22], if_pd)
		`CHK("rf_pd", rfb[22], rf_pd)
		`CHK("if_hiz", ir[18] | ifb[22], if_hiz)
		`CHK("rf_hiz", rr[18] | rfb[22], rf_hiz)
		// pumps are idle whenever this runs, so analog selects sit released
		`CHK("status", sel == 4'hb, smo)
		`CHK("status_oe_n", alk, smo_oe_n)
	endtask

	task automatic wait_p(input int n);
		while (p < n) @(posedge clk_i);
		@(negedge clk_i);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		for (int i = 0; i < 4; i++) begin
			lat[i] = 24'h000000;
		end
		w = $urandom(80);
		repeat (4) @(posedge clk_i);
		rstn_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		check();
		@(posedge clk_i);
		// every select code three times; word 5 is shifted but never loaded
		for (int i = 0; i < 12; i++) begin
			w = $urandom;
			w[1:0] = i[1:0];
			host.send_word(w, i != 5);
			if (i != 5) lat[w[1:0]] = w;
			check();
			@(posedge clk_i);
		end
		// power down first so both swallow counters restart from zero
		host.send_word(24'h400101, 1'b1);
		host.send_word(24'h400103, 1'b1);
		// IF positive and RF negative polarity, ratio 1, status shows IF lock
		host.send_word(24'haa0004, 1'b1);
		host.send_word(24'h000101, 1'b1);
		host.send_word(24'h000103, 1'b1);
		host.send_word(24'h000002, 1'b1);
		lat[0] = 24'haa0004;
		lat[1] = 24'h000101;
		lat[2] = 24'h000002;
		lat[3] = 24'h000103;
		check();
		@(posedge clk_i);
		run <= 1'b1;
		wait_p(80);
		`CHK("lock_after_two", 1'b0, smo)
		wait_p(128);
		// aligned edges give one cycle with both pumps on, then both off
		`CHK("if_up_abl", 1'b1, if_up)
		`CHK("if_dn_abl", 1'b1, if_dn)
		`CHK("rf_up_abl", 1'b1, rf_up)
		`CHK("rf_dn_abl", 1'b1, rf_dn)
		wait_p(129);
		`CHK("if_up_off", 1'b0, if_up)
		`CHK("rf_dn_off", 1'b0, rf_dn)
		wait_p(140);
		`CHK("lock_after_three", 1'b1, smo)
		wait_p(292);
		// reference leads by 8 cycles after the missed vco pulses
		`CHK("if_up_lead", 1'b1, if_up)
		`CHK("if_dn_lead", 1'b0, if_dn)
		`CHK("rf_up_lead", 1'b0, rf_up)
		`CHK("rf_dn_lead", 1'b1, rf_dn)
		wait_p(360);
		`CHK("lock_lost", 1'b0, smo)
		results();
	end

	initial begin
		// eighteen words at about 510 cycles each plus the lock run
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		results();
	end

endmodule

`default_nettype wire
